// *** core/dspm_pin_mux.sv ***
// per-pin choice between port data and display drive for one port
`timescale 1ns/100ps
module dspm_pin_mux (
    input wire dspm_pkg::dspm_sel_t sel,
    input wire logic keyScan,
    input wire logic [7:0] dataReg,
    input wire logic [7:0] segDrv,
    input wire logic [7:0] digDrv,
    input wire logic [7:0] pinIn,
    output dspm_pkg::dspm_pins_t pinNext,
    output logic [7:0] readVal,
    output logic [7:0] taken
);
    logic [7:0] val;

    for (genvar n = 0; n < 8; n++)
    begin : g_pin
        // key scan hands taken pins back to the port for its duration
        assign taken[n] = (sel.seg[n] | sel.dig[n]) & ~keyScan; // RULE_04 RULE_08
        assign val[n] = taken[n] ? (sel.dig[n] ? digDrv[n] : segDrv[n]) : dataReg[n];
        // a taken pin reads back the data register, a free pin its level
        assign readVal[n] = taken[n] ? dataReg[n] : pinIn[n]; // RULE_06
    end

    // high-voltage pins source only a high; a low is the pull-down,
    // which leaves a released pin readable from outside
    assign pinNext = '{dout: val, oe: val, pd: ~val}; // RULE_14
endmodule : dspm_pin_mux

// *** core/dspm_pkg.sv ***
// constants and types of the display shared port mux
package dspm_pkg;
    localparam logic [15:0] ADDR_PORT5 = 16'hFFD5;
    localparam logic [15:0] ADDR_PORT6 = 16'hFFD6;
    localparam logic [15:0] ADDR_PORT7 = 16'hFFD7;
    localparam logic [15:0] ADDR_SEGCTL = 16'hFFF0;
    localparam logic [15:0] ADDR_DIGCTL = 16'hFFF1;
    localparam logic [15:0] ADDR_DSTART = 16'hFFF2;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] MASK_SEGCTL = 8'h9F;
    localparam logic [7:0] MASK_DIGCTL = 8'h0F;
    localparam logic [7:0] MASK_DSTART = 8'h8F;
    localparam int FLAG_BIT = 7;
    localparam int DRVEN_BIT = 7;
    localparam int SEGR_MSB = 4;
    localparam int DIGR_MSB = 3;
    localparam int DSTART_MSB = 3;

    // segment and digit index carried by bit 0 side of each port group
    localparam int SEG_P5_TOP = 15;
    localparam int SEG_P6_TOP = 7;
    localparam int DIG_P6_BASE = 0;
    localparam int DIG_P7_BASE = 8;

    typedef enum logic [2:0] {
        PM_ACTIVE,
        PM_SLEEP,
        PM_STANDBY,
        PM_WATCH,
        PM_SUBACTIVE
    } dspm_power_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dspm_bus_t;

    typedef struct packed {
        logic [15:0] seg;
        logic [15:0] dig;
    } dspm_drive_t;

    typedef struct packed {
        logic flag;
        logic driveEn;
        logic [4:0] segRange;
        logic [3:0] digRange;
        logic [3:0] digStart;
    } dspm_ctrl_t;

    typedef struct packed {
        logic [7:0] seg;
        logic [7:0] dig;
    } dspm_sel_t;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] pd;
    } dspm_pins_t;

    localparam dspm_pins_t PINS_OFF = '{dout: 8'h00, oe: 8'h00, pd: 8'hFF};
endpackage : dspm_pkg

// *** core/dspm_port_mux.sv ***
// top: register port, pin sharing and pin registers of ports 5 to 7
`timescale 1ns/100ps
// Operation
// [RULE_01] flag 0: port 5 all general I/O
// [RULE_02] flag 1: ranged port 5 pins become segments
// [RULE_03] software sets ranges before drive enable
// [RULE_04] key scan: port 5 segment pins CPU-accessible
// [RULE_05] clearing flag frees port 5 segment pins
// [RULE_06] taken port 5 pin reads data register
// [RULE_07] port 6 role from three range fields
// [RULE_08] key scan: port 6 taken pins CPU-accessible
// [RULE_09] flag 0 makes port 6 general I/O
// [RULE_10] taken port 6 pin reads data register
// [RULE_11] port 6 register eight bits, reset zero
// [RULE_12] port 7 register eight bits, reset zero
// [RULE_13] port 6 pin state per power mode
// [RULE_14] ports 6, 7 eight bidirectional pins each
// [RULE_15] flag 1: ranged port 7 pins become digits
// [RULE_16] port 5 register eight bits, reset zero
// [RULE_17] segments count against bit order, digits with
module dspm_port_mux (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dspm_pkg::dspm_bus_t bus,
    output logic [7:0] rdData,
    input wire logic keyScan,
    input wire dspm_pkg::dspm_power_t powerMode,
    input wire dspm_pkg::dspm_drive_t drive,
    input wire logic [7:0] pin5In,
    input wire logic [7:0] pin6In,
    input wire logic [7:0] pin7In,
    output dspm_pkg::dspm_pins_t pin5,
    output dspm_pkg::dspm_pins_t pin6,
    output dspm_pkg::dspm_pins_t pin7,
    output dspm_pkg::dspm_ctrl_t ctrl
);
    logic rstMeta_q;
    logic rstSync_q;
    logic [7:0] port5_q;
    logic [7:0] port5_d;
    logic [7:0] port6_q;
    logic [7:0] port6_d;
    logic [7:0] port7_q;
    logic [7:0] port7_d;
    logic [7:0] segCtl_q;
    logic [7:0] segCtl_d;
    logic [7:0] digCtl_q;
    logic [7:0] digCtl_d;
    logic [7:0] dStart_q;
    logic [7:0] dStart_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    dspm_pkg::dspm_pins_t pin5_q;
    dspm_pkg::dspm_pins_t pin5_d;
    dspm_pkg::dspm_pins_t pin6_q;
    dspm_pkg::dspm_pins_t pin6_d;
    dspm_pkg::dspm_pins_t pin7_q;
    dspm_pkg::dspm_pins_t pin7_d;
    dspm_pkg::dspm_pins_t next5;
    dspm_pkg::dspm_pins_t next6;
    dspm_pkg::dspm_pins_t next7;
    dspm_pkg::dspm_sel_t sel5;
    dspm_pkg::dspm_sel_t sel6;
    dspm_pkg::dspm_sel_t sel7;
    logic [7:0] read5;
    logic [7:0] read6;
    logic [7:0] read7;
    logic [7:0] taken5;
    logic [7:0] taken6;
    logic [7:0] taken7;
    logic [7:0] seg5Drv;
    logic [7:0] seg6Drv;
    logic [7:0] dig6Drv;
    logic [7:0] dig7Drv;
    logic firstCyc_q;

    // reset is released through two flops; the first feeds only the second
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // the controller is told only by these; ranges must settle before
    // driveEn, software keeps that order
    assign ctrl = '{
        flag: segCtl_q[dspm_pkg::FLAG_BIT],
        driveEn: dStart_q[dspm_pkg::DRVEN_BIT],
        segRange: segCtl_q[dspm_pkg::SEGR_MSB:0],
        digRange: digCtl_q[dspm_pkg::DIGR_MSB:0],
        digStart: dStart_q[dspm_pkg::DSTART_MSB:0]
    }; // RULE_03

    // controller vectors onto pin bits: segments reversed, digits in order
    for (genvar n = 0; n < 8; n++)
    begin : g_map
        assign seg5Drv[n] = drive.seg[dspm_pkg::SEG_P5_TOP - n]; // RULE_17
        assign seg6Drv[n] = drive.seg[dspm_pkg::SEG_P6_TOP - n]; // RULE_17
        assign dig6Drv[n] = drive.dig[dspm_pkg::DIG_P6_BASE + n]; // RULE_17
        assign dig7Drv[n] = drive.dig[dspm_pkg::DIG_P7_BASE + n];
    end

    dspm_range_decode u_decode (
        .ctrl (ctrl),
        .sel5 (sel5),
        .sel6 (sel6),
        .sel7 (sel7)
    );

    dspm_pin_mux u_mux5 (
        .sel (sel5),
        .keyScan (keyScan),
        .dataReg (port5_q),
        .segDrv (seg5Drv),
        .digDrv (8'h00),
        .pinIn (pin5In),
        .pinNext (next5),
        .readVal (read5),
        .taken (taken5)
    );

    dspm_pin_mux u_mux6 (
        .sel (sel6),
        .keyScan (keyScan),
        .dataReg (port6_q),
        .segDrv (seg6Drv),
        .digDrv (dig6Drv),
        .pinIn (pin6In),
        .pinNext (next6),
        .readVal (read6),
        .taken (taken6)
    );

    dspm_pin_mux u_mux7 (
        .sel (sel7),
        .keyScan (keyScan),
        .dataReg (port7_q),
        .segDrv (8'h00),
        .digDrv (dig7Drv),
        .pinIn (pin7In),
        .pinNext (next7),
        .readVal (read7),
        .taken (taken7)
    );

    // data and control registers; data writes land even on taken pins
    always_comb
    begin
        port5_d = port5_q;
        port6_d = port6_q;
        port7_d = port7_q;
        segCtl_d = segCtl_q;
        digCtl_d = digCtl_q;
        dStart_d = dStart_q;
        if (bus.wr)
        begin
            case (bus.addr)
                dspm_pkg::ADDR_PORT5: port5_d = bus.wdata; // RULE_16
                dspm_pkg::ADDR_PORT6: port6_d = bus.wdata; // RULE_11
                dspm_pkg::ADDR_PORT7: port7_d = bus.wdata; // RULE_12
                dspm_pkg::ADDR_SEGCTL: segCtl_d = bus.wdata & dspm_pkg::MASK_SEGCTL; // RULE_05
                dspm_pkg::ADDR_DIGCTL: digCtl_d = bus.wdata & dspm_pkg::MASK_DIGCTL;
                dspm_pkg::ADDR_DSTART: dStart_d = bus.wdata & dspm_pkg::MASK_DSTART;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            port5_q <= dspm_pkg::DATA_RST; // RULE_16
            port6_q <= dspm_pkg::DATA_RST; // RULE_11
            port7_q <= dspm_pkg::DATA_RST; // RULE_12
            segCtl_q <= dspm_pkg::DATA_RST;
            digCtl_q <= dspm_pkg::DATA_RST;
            dStart_q <= dspm_pkg::DATA_RST;
        end
        else
        begin
            port5_q <= port5_d;
            port6_q <= port6_d;
            port7_q <= port7_d;
            segCtl_q <= segCtl_d;
            digCtl_q <= digCtl_d;
            dStart_q <= dStart_d;
        end
    end

    // read data stand for one cycle only; unmapped addresses read zero
    always_comb
    begin
        rdData_d = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                dspm_pkg::ADDR_PORT5: rdData_d = read5; // RULE_06
                dspm_pkg::ADDR_PORT6: rdData_d = read6; // RULE_10
                dspm_pkg::ADDR_PORT7: rdData_d = read7; // RULE_15
                dspm_pkg::ADDR_SEGCTL: rdData_d = segCtl_q;
                dspm_pkg::ADDR_DIGCTL: rdData_d = digCtl_q;
                dspm_pkg::ADDR_DSTART: rdData_d = dStart_q;
                default: rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            rdData_q <= dspm_pkg::DATA_RST;
        end
        else
        begin
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;

    // pin registers follow the power mode; sleep freezes them in place
    always_comb
    begin
        pin5_d = pin5_q;
        pin6_d = pin6_q;
        pin7_d = pin7_q;
        unique case (powerMode)
            dspm_pkg::PM_ACTIVE:
            begin
                pin5_d = next5;
                pin6_d = next6; // RULE_13
                pin7_d = next7;
            end
            dspm_pkg::PM_SLEEP:
            begin
                pin5_d = pin5_q;
                pin6_d = pin6_q; // RULE_13
                pin7_d = pin7_q;
            end
            default:
            begin
                pin5_d = dspm_pkg::PINS_OFF;
                pin6_d = dspm_pkg::PINS_OFF; // RULE_13
                pin7_d = dspm_pkg::PINS_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            pin5_q <= dspm_pkg::PINS_OFF;
            pin6_q <= dspm_pkg::PINS_OFF; // RULE_13
            pin7_q <= dspm_pkg::PINS_OFF;
        end
        else
        begin
            pin5_q <= pin5_d;
            pin6_q <= pin6_d;
            pin7_q <= pin7_d;
        end
    end

    assign pin5 = pin5_q;
    assign pin6 = pin6_q;
    assign pin7 = pin7_q;

    // marks the first cycle after reset release, for checking only
    always_ff @(posedge core_clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            firstCyc_q <= 1'b1;
        end
        else
        begin
            firstCyc_q <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstSync_q);

    sequence sActive;
        powerMode == dspm_pkg::PM_ACTIVE;
    endsequence

    sequence sClearFlag;
        bus.wr && bus.addr == dspm_pkg::ADDR_SEGCTL && !bus.wdata[dspm_pkg::FLAG_BIT];
    endsequence

    sequence sDisplayOn;
        sActive ##0 ctrl.flag && !keyScan;
    endsequence

    a_flag_off_gpio: assert property ( // RULE_01
        sActive ##0 !ctrl.flag |=> pin5_q.dout == $past(port5_q)
            && pin6_q.dout == $past(port6_q) && pin7_q.dout == $past(port7_q))
        else $error("flag low but a pin is not driven from its data register");

    a_p5_segment_drive: assert property ( // RULE_02
        sDisplayOn |=> ((pin5_q.dout ^ $past(seg5Drv)) & $past(sel5.seg)) == 8'h00)
        else $error("port 5 segment pin does not follow segment drive");

    a_keyscan_release: assert property ( // RULE_04
        sActive ##0 keyScan |=> pin5_q.dout == $past(port5_q)
            && pin6_q.dout == $past(port6_q))
        else $error("key scan did not return pins to their data registers");

    a_flag_clear_frees: assert property ( // RULE_05
        sClearFlag ##1 sActive |=> pin5_q.dout == $past(port5_q)
            && pin6_q.dout == $past(port6_q))
        else $error("clearing the flag did not free display pins");

    a_taken_read_data: assert property ( // RULE_06
        bus.rd && bus.addr == dspm_pkg::ADDR_PORT5
            |=> ((rdData_q ^ $past(port5_q)) & $past(taken5)) == 8'h00)
        else $error("taken port 5 pin read back something other than data");

    a_p6_digit_drive: assert property ( // RULE_07
        sDisplayOn |=> ((pin6_q.dout ^ $past(dig6Drv)) & $past(sel6.dig)) == 8'h00
            && ((pin6_q.dout ^ $past(seg6Drv)) & $past(sel6.seg)) == 8'h00)
        else $error("port 6 display pin does not follow its drive");

    a_p6_taken_read: assert property ( // RULE_10
        bus.rd && bus.addr == dspm_pkg::ADDR_PORT6
            |=> ((rdData_q ^ $past(port6_q)) & $past(taken6)) == 8'h00)
        else $error("taken port 6 pin read back something other than data");

    a_reset_values: assert property ( // RULE_11
        firstCyc_q |-> port5_q == dspm_pkg::DATA_RST
            && port6_q == dspm_pkg::DATA_RST && port7_q == dspm_pkg::DATA_RST)
        else $error("a data register is not zero after reset");

    a_p7_write_store: assert property ( // RULE_12
        bus.wr && bus.addr == dspm_pkg::ADDR_PORT7
            |=> port7_q == $past(bus.wdata))
        else $error("port 7 data register did not take the write");

    a_power_off_pins: assert property ( // RULE_13
        powerMode inside {dspm_pkg::PM_STANDBY, dspm_pkg::PM_WATCH,
            dspm_pkg::PM_SUBACTIVE} |=> pin6_q == dspm_pkg::PINS_OFF)
        else $error("port 6 not released in a low-power mode");

    a_sleep_holds: assert property ( // RULE_13
        powerMode == dspm_pkg::PM_SLEEP |=> $stable(pin6_q))
        else $error("port 6 changed during sleep");

    a_p7_digit_drive: assert property ( // RULE_15
        sDisplayOn ##0 sel7.dig[0] |=> pin7_q.dout[0] == $past(drive.dig[8]))
        else $error("port 7 bit 0 does not follow digit 8");

    a_segment_order: assert property ( // RULE_17
        sDisplayOn ##0 sel5.seg[7] |=> pin5_q.dout[7] == $past(drive.seg[8]))
        else $error("port 5 bit 7 does not follow segment 8");
endmodule : dspm_port_mux

// *** core/dspm_range_decode.sv ***
// decode of the range fields into per-pin takeover masks
`timescale 1ns/100ps
module dspm_range_decode (
    input wire dspm_pkg::dspm_ctrl_t ctrl,
    output dspm_pkg::dspm_sel_t sel5,
    output dspm_pkg::dspm_sel_t sel6,
    output dspm_pkg::dspm_sel_t sel7
);
    logic [7:0] seg5;
    logic [7:0] seg6;
    logic [7:0] dig6;
    logic [7:0] dig7;

    // digits run from the start index through start plus range
    function automatic logic digUsed(
        input logic [4:0] idx,
        input logic [3:0] start,
        input logic [3:0] span
    );
        logic [4:0] last;
        last = 5'(start) + 5'(span);
        return (idx >= 5'(start)) && (idx <= last);
    endfunction : digUsed

    for (genvar n = 0; n < 8; n++)
    begin : g_bit
        localparam logic [4:0] S5 = 5'(dspm_pkg::SEG_P5_TOP - n);
        localparam logic [4:0] S6 = 5'(dspm_pkg::SEG_P6_TOP - n);
        localparam logic [4:0] D6 = 5'(dspm_pkg::DIG_P6_BASE + n);
        localparam logic [4:0] D7 = 5'(dspm_pkg::DIG_P7_BASE + n);
        // segment k is in use while k stays below the range count
        assign seg5[n] = ctrl.flag & (S5 < ctrl.segRange); // RULE_01
        assign dig6[n] = ctrl.flag & digUsed(D6, ctrl.digStart, ctrl.digRange); // RULE_07
        // a pin claimed as digit is never also a segment
        assign seg6[n] = ctrl.flag & ~dig6[n] & (S6 < ctrl.segRange); // RULE_09
        assign dig7[n] = ctrl.flag & digUsed(D7, ctrl.digStart, ctrl.digRange); // RULE_15
    end

    assign sel5 = '{seg: seg5, dig: 8'h00}; // RULE_02
    assign sel6 = '{seg: seg6, dig: dig6};
    assign sel7 = '{seg: 8'h00, dig: dig7};
endmodule : dspm_range_decode

// *** verif/dspm_panel_model.sv ***
// pin-level model of the panel and board wiring on one port
`timescale 1ns/100ps
module dspm_panel_model (
    input wire logic core_clk,
    input wire dspm_pkg::dspm_pins_t pins,
    input wire logic [7:0] ext,
    output logic [7:0] level
);
    logic [7:0] floatQ = 8'hA5;

    // an unpulled, undriven line wanders so that a stale level never reads back
    always @(posedge core_clk)
    begin
        floatQ <= ~floatQ;
    end

    // ext models a board source that pulls a line high over the weak pull-down
    assign level = (pins.oe & pins.dout) | ext | (~pins.oe & ~pins.pd & floatQ);
endmodule : dspm_panel_model

// *** verif/dspm_port_mux_tb_top.sv ***
// self-checking bench of the display shared port mux
`timescale 1ns/100ps
module dspm_port_mux_tb_top;
    logic core_clk;
    logic rst_n;
    dspm_pkg::dspm_bus_t bus;
    logic [7:0] rdData;
    logic keyScan;
    dspm_pkg::dspm_power_t powerMode;
    dspm_pkg::dspm_drive_t drv;
    dspm_pkg::dspm_pins_t pins [3];
    dspm_pkg::dspm_ctrl_t ctrl;
    logic [7:0] lvl [3];
    logic [7:0] ext [3];
    logic [7:0] regs [3];
    logic [15:0] hold [3];
    logic flag;
    logic de;
    logic [4:0] segR;
    logic [3:0] digR;
    logic [3:0] digS;
    logic rdPend;
    logic [7:0] expQ [$];
    dspm_pkg::dspm_power_t offModes [3];
    int n_fail;
    int compares;

    dspm_port_mux u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(bus),
        .rdData(rdData),
        .keyScan(keyScan),
        .powerMode(powerMode),
        .drive(drv),
        .pin5In(lvl[0]),
        .pin6In(lvl[1]),
        .pin7In(lvl[2]),
        .pin5(pins[0]),
        .pin6(pins[1]),
        .pin7(pins[2]),
        .ctrl(ctrl)
    );

    for (genvar g = 0; g < 3; g++)
    begin : g_panel
        dspm_panel_model u_panel (
            .core_clk(core_clk),
            .pins(pins[g]),
            .ext(ext[g]),
            .level(lvl[g])
        );
    end

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_st(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: state %h expected %h", $time, got, exp);
        end
    endtask : cmp_st

    // read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge core_clk)
    begin
        if (rdPend === 1'b1)
            cmp_rd(rdData, expQ.pop_front());
        else if (rst_n === 1'b1)
            cmp_rd(rdData, 8'h00);
        rdPend <= bus.rd;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        for (int p = 0; p < 3; p++)
            if (a == dspm_pkg::ADDR_PORT5 + 16'(p))
                regs[p] = d;
        if (a == dspm_pkg::ADDR_SEGCTL)
            {flag, segR} = {d[7], d[4:0]};
        if (a == dspm_pkg::ADDR_DIGCTL)
            digR = d[3:0];
        if (a == dspm_pkg::ADDR_DSTART)
            {de, digS} = {d[7], d[3:0]};
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    endtask : rd_chk

    // upper byte: pins that the display holds, lower byte: level each pin drives
    function automatic logic [15:0] expect_port(input int p);
        logic [7:0] tk;
        logic [7:0] dv;
        int k;
        int s;
        tk = 8'h00;
        dv = 8'h00;
        for (int n = 0; n < 8; n++)
        begin
            k = (p == 2) ? 8 + n : n;
            s = (p == 0) ? 15 - n : 7 - n;
            if (p != 0 && k >= digS && k <= digS + digR)
            begin
                tk[n] = flag;
                dv[n] = drv.dig[k];
            end
            else if (p != 2 && s < segR)
            begin
                tk[n] = flag;
                dv[n] = drv.seg[s];
            end
        end
        tk = tk & ~{8{keyScan}};
        return {tk, (tk & dv) | (~tk & regs[p])};
    endfunction : expect_port

    task automatic settle_chk();
        logic [15:0] e;
        repeat (3) @(posedge core_clk);
        #1;
        cmp_st({9'h000, ctrl}, {9'h000, flag, de, segR, digR, digS});
        for (int p = 0; p < 3; p++)
        begin
            e = expect_port(p);
            cmp_st({pins[p].dout, pins[p].oe, pins[p].pd}, {e[7:0], e[7:0], ~e[7:0]});
            rd_chk(dspm_pkg::ADDR_PORT5 + 16'(p),
                (e[15:8] & regs[p]) | (~e[15:8] & (e[7:0] | ext[p])));
        end
    endtask : settle_chk

    task automatic shuffle();
        for (int p = 0; p < 3; p++)
        begin
            wr(dspm_pkg::ADDR_PORT5 + 16'(p), 8'($urandom));
            ext[p] <= 8'($urandom);
        end
        drv <= $urandom;
    endtask : shuffle

    task automatic start_display(input logic [4:0] s, input logic [3:0] r, input logic [3:0] b);
        wr(dspm_pkg::ADDR_DIGCTL, {4'h0, r});
        wr(dspm_pkg::ADDR_DSTART, {4'h0, b});
        wr(dspm_pkg::ADDR_SEGCTL, {3'b100, s});
        wr(dspm_pkg::ADDR_DSTART, {4'h8, b});
    endtask : start_display

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        logic [4:0] segTab [6];
        segTab = '{5'h00, 5'h08, 5'h10, 5'h1F, 5'h03, 5'h0C};
        offModes = '{dspm_pkg::PM_STANDBY, dspm_pkg::PM_WATCH, dspm_pkg::PM_SUBACTIVE};
        n_fail = 0;
        compares = 0;
        rst_n = 1'b0;
        bus = '0;
        keyScan = 1'b0;
        powerMode = dspm_pkg::PM_ACTIVE;
        drv = '0;
        ext = '{default: 8'h00};
        regs = '{default: 8'h00};
        {flag, de, segR, digR, digS} = '0;
        void'($urandom(32'hE5C0));
        repeat (10) @(posedge core_clk);
        #1;
        for (int p = 0; p < 3; p++)
            cmp_st(pins[p], dspm_pkg::PINS_OFF);
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        settle_chk();
        // ranges set but takeover off: every pin stays a port
        shuffle();
        wr(dspm_pkg::ADDR_SEGCTL, 8'h10);
        wr(dspm_pkg::ADDR_DIGCTL, 8'h0F);
        settle_chk();
        for (int i = 0; i < 6; i++)
        begin
            shuffle();
            start_display(segTab[i], 4'($urandom), 4'($urandom));
            settle_chk();
            @(posedge core_clk);
            keyScan <= 1'b1;
            settle_chk();
            @(posedge core_clk);
            keyScan <= 1'b0;
        end
        wr(dspm_pkg::ADDR_SEGCTL, {3'b000, segR});
        settle_chk();
        // reserved bits ignored, widest ranges
        wr(dspm_pkg::ADDR_SEGCTL, 8'hFF);
        wr(dspm_pkg::ADDR_DIGCTL, 8'hFF);
        wr(dspm_pkg::ADDR_DSTART, 8'hFF);
        // reserved bits of the control registers read back as zero
        rd_chk(dspm_pkg::ADDR_SEGCTL, dspm_pkg::MASK_SEGCTL);
        rd_chk(dspm_pkg::ADDR_DIGCTL, dspm_pkg::MASK_DIGCTL);
        rd_chk(dspm_pkg::ADDR_DSTART, dspm_pkg::MASK_DSTART);
        settle_chk();
        wr(16'hFFD8, 8'($urandom));
        rd_chk(16'hFFD8, 8'h00);
        rd_chk(16'hFFF3, 8'h00);
        settle_chk();
        for (int p = 0; p < 3; p++)
            hold[p] = expect_port(p);
        @(posedge core_clk);
        powerMode <= dspm_pkg::PM_SLEEP;
        wr(dspm_pkg::ADDR_PORT6, ~regs[1]);
        drv <= ~drv;
        repeat (3) @(posedge core_clk);
        #1;
        for (int p = 0; p < 3; p++)
            cmp_st({pins[p].dout, pins[p].oe, pins[p].pd},
                {hold[p][7:0], hold[p][7:0], ~hold[p][7:0]});
        for (int m = 0; m < 3; m++)
        begin
            @(posedge core_clk);
            powerMode <= dspm_pkg::PM_ACTIVE;
            repeat (3) @(posedge core_clk);
            powerMode <= offModes[m];
            repeat (3) @(posedge core_clk);
            #1;
            for (int p = 0; p < 3; p++)
                cmp_st(pins[p], dspm_pkg::PINS_OFF);
        end
        @(posedge core_clk);
        powerMode <= dspm_pkg::PM_ACTIVE;
        settle_chk();
        repeat (3) @(posedge core_clk);
        tally_and_finish();
    end
endmodule : dspm_port_mux_tb_top
